// *** hdl/hbc_chopper.sv ***
`timescale 1ns/1ps
`include "hbc_defines.svh"

module hbc_chopper #(
	parameter int WAKE_CYCLES = `HBC_WAKE_NS / `HBC_CLK_NS
) (
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              rstn,
	// Avalon-MM register slave.
	input  wire logic [4:0]        address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	// Control pins from the external controller.
	input  wire logic              low_power_n,
	input  wire logic              chan_a_drive_ctl_1,
	input  wire logic              chan_a_drive_ctl_2,
	input  wire logic              chan_b_drive_ctl_1,
	input  wire logic              chan_b_drive_ctl_2,
	// Sense path from the analog front end.
	input  wire hbc_pkg::hbc_code_t chan_a_sense_code,
	input  wire hbc_pkg::hbc_code_t chan_b_sense_code,
	input  wire logic              chan_a_zero_cur,
	input  wire logic              chan_b_zero_cur,
	output hbc_pkg::hbc_gain_t     sense_gain_sel,
	// Gate enables, bits high-side 1, low-side 1, high-side 2, low-side 2.
	output hbc_pkg::hbc_gate_t     chan_a_gate,
	output hbc_pkg::hbc_gate_t     chan_b_gate
);
	import hbc_pkg::*;

	function automatic logic [7:0] blank_cyc(input logic [7:0] sel);
		int ns;
		ns = `HBC_BLANK_BASE_NS + int'(sel) * `HBC_BLANK_STEP_NS;
		blank_cyc = 8'((ns + `HBC_CLK_NS - 1) / `HBC_CLK_NS - 1);
	endfunction : blank_cyc

	function automatic logic [11:0] off_cyc(input logic [7:0] sel);
		int ns;
		ns = `HBC_OFF_BASE_NS + int'(sel) * `HBC_OFF_STEP_NS;
		off_cyc = 12'((ns + `HBC_CLK_NS - 1) / `HBC_CLK_NS - 1);
	endfunction : off_cyc

	function automatic logic [11:0] fast_cyc(input logic [7:0] sel);
		fast_cyc = 12'(int'(sel) * `HBC_FAST_STEP_NS / `HBC_CLK_NS);
	endfunction : fast_cyc

	function automatic hbc_gate_t drive_gates(input logic fwd);
		hbc_gate_t g;
		g = 4'h0;
		if (fwd) begin
			g[`HBC_HS1] = 1'b1;
			g[`HBC_LS2] = 1'b1;
		end else begin
			g[`HBC_LS1] = 1'b1;
			g[`HBC_HS2] = 1'b1;
		end
		drive_gates = g;
	endfunction : drive_gates

	function automatic hbc_gate_t brake_gates();
		hbc_gate_t g;
		g = 4'h0;
		g[`HBC_LS1] = 1'b1;
		g[`HBC_LS2] = 1'b1;
		brake_gates = g;
	endfunction : brake_gates

	// Pins come from outside the clock domain; two flops before use.
	logic [6:0] sync1;
	logic [6:0] sync2;
	logic [6:0] pins;
	assign pins = {chan_b_zero_cur, chan_a_zero_cur,
		chan_b_drive_ctl_2, chan_b_drive_ctl_1,
		chan_a_drive_ctl_2, chan_a_drive_ctl_1, low_power_n};

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sync1 <= 7'h00;
			sync2 <= 7'h00;
		end else begin
			sync1 <= pins;
			sync2 <= sync1;
		end
	end

	// Configuration and bus state.
	logic [`HBC_CTRL_W-1:0] ctrl, next_ctrl;
	logic [7:0]  scale, next_scale;
	logic [7:0]  off_sel, next_off_sel;
	logic [7:0]  blank_sel, next_blank_sel;
	logic [7:0]  fast_sel, next_fast_sel;
	logic        ack, next_ack;
	logic [31:0] next_readdata;
	logic [31:0] status;
	logic        bridge_enable_bit;
	hbc_decay_t  decay_sel;

	assign bridge_enable_bit = ctrl[`HBC_CTRL_EN];
	assign decay_sel = hbc_decay_t'(ctrl[`HBC_CTRL_DECAY]);
	// The slave always inserts one wait state so read data can be
	// registered; every access completes on the second edge.
	assign waitrequest = (read | write) & ~ack;

	// Wake timer.
	logic [15:0] wake_cnt, next_wake_cnt;
	logic        awake, next_awake;

	// Channel state.
	hbc_state_t st [2];
	hbc_state_t next_st [2];
	logic [1:0]  dir, next_dir;
	logic [1:0]  zero, next_zero;
	logic [7:0]  blk [2];
	logic [7:0]  next_blk [2];
	logic [11:0] tmr [2];
	logic [11:0] next_tmr [2];
	logic [11:0] fcnt [2];
	logic [11:0] next_fcnt [2];
	hbc_gate_t   gate [2];
	hbc_gate_t   next_gate [2];
	logic [1:0]  trip;
	logic [1:0]  in1, in2, zdet;

	assign in1  = {sync2[3], sync2[1]};
	assign in2  = {sync2[4], sync2[2]};
	assign zdet = {sync2[6], sync2[5]};

	assign sense_gain_sel = ctrl[`HBC_CTRL_GAIN];
	assign trip[0] = chan_a_sense_code >= scale;
	assign trip[1] = chan_b_sense_code >= scale;

	assign chan_a_gate = gate[0];
	assign chan_b_gate = gate[1];

	assign status = {19'h0, zero, awake, st[1], st[0]};

	always_comb begin
		next_ctrl      = ctrl;
		next_scale     = scale;
		next_off_sel   = off_sel;
		next_blank_sel = blank_sel;
		next_fast_sel  = fast_sel;
		next_readdata  = readdata;
		next_ack       = (read | write) & ~ack;
		if (read & ~ack) begin
			unique case (address)
			`HBC_OFS_CTRL:   next_readdata = {27'h0, ctrl};
			`HBC_OFS_SCALE:  next_readdata = {24'h0, scale};
			`HBC_OFS_OFF:    next_readdata = {24'h0, off_sel};
			`HBC_OFS_BLANK:  next_readdata = {24'h0, blank_sel};
			`HBC_OFS_FAST:   next_readdata = {24'h0, fast_sel};
			`HBC_OFS_STATUS: next_readdata = status;
			default:         next_readdata = 32'h0;
			endcase
		end
		if (write & ack & byteenable[0]) begin
			unique case (address)
			`HBC_OFS_CTRL:  next_ctrl = writedata[`HBC_CTRL_W-1:0];
			`HBC_OFS_SCALE: next_scale = writedata[7:0];
			`HBC_OFS_OFF:   next_off_sel = writedata[7:0];
			`HBC_OFS_BLANK: next_blank_sel = writedata[7:0];
			`HBC_OFS_FAST:  next_fast_sel = writedata[7:0];
			default:        next_ctrl = ctrl;
			endcase
		end
	end

	always_comb begin
		next_wake_cnt = wake_cnt;
		next_awake    = awake;
		if (!sync2[0]) begin
			next_wake_cnt = 16'h0;
			next_awake    = 1'b0;
		end else if (!awake) begin
			if (int'(wake_cnt) >= WAKE_CYCLES - 1) begin
				next_awake = 1'b1;
			end else begin
				next_wake_cnt = wake_cnt + 16'h1;
			end
		end
	end

	always_comb begin
		next_dir  = dir;
		next_zero = zero;
		for (int i = 0; i < 2; i++) begin
			next_st[i]   = st[i];
			next_blk[i]  = blk[i];
			next_tmr[i]  = tmr[i];
			next_fcnt[i] = fcnt[i];
			next_gate[i] = 4'h0;
			if (!(awake && bridge_enable_bit)) begin
				next_st[i] = HBC_IDLE;
			end else if (in1[i] == in2[i]) begin
				next_st[i] = HBC_IDLE;
				if (in1[i]) begin
					next_gate[i] = brake_gates();
				end
			end else begin
				if (st[i] == HBC_IDLE || dir[i] != in1[i]) begin
					next_st[i]  = HBC_BLANK;
					next_dir[i] = in1[i];
					next_blk[i] = blank_cyc(blank_sel);
				end else begin
					unique case (st[i])
					HBC_IDLE: next_st[i] = HBC_BLANK;
					HBC_BLANK: begin
						if (blk[i] != 8'h0) begin
							next_blk[i] = blk[i] - 8'h1;
						end else if (decay_sel == HBC_DEC_AUTO
							&& trip[i]) begin
							next_st[i]   = HBC_FAST;
							next_tmr[i]  = off_cyc(off_sel);
							next_blk[i]  = blank_cyc(blank_sel);
							next_zero[i] = 1'b0;
						end else begin
							next_st[i] = HBC_ON;
						end
					end
					HBC_ON: begin
						if (trip[i]) begin
							next_tmr[i]  = off_cyc(off_sel);
							next_fcnt[i] = fast_cyc(fast_sel);
							next_blk[i]  = blank_cyc(blank_sel);
							next_zero[i] = 1'b0;
							unique case (decay_sel)
							HBC_DEC_FAST:  next_st[i] = HBC_FAST;
							HBC_DEC_MIXED: next_st[i] = HBC_FAST;
							HBC_DEC_SLOW:  next_st[i] = HBC_SLOW;
							HBC_DEC_AUTO:  next_st[i] = HBC_SLOW;
							endcase
						end
					end
					HBC_FAST: begin
						if (tmr[i] == 12'h0) begin
							next_st[i]  = HBC_BLANK;
							next_blk[i] = blank_cyc(blank_sel);
						end else begin
							next_tmr[i] = tmr[i] - 12'h1;
							if (zdet[i]) begin
								next_zero[i] = 1'b1;
							end
							if (fcnt[i] != 12'h0) begin
								next_fcnt[i] = fcnt[i] - 12'h1;
							end
							if (blk[i] != 8'h0) begin
								next_blk[i] = blk[i] - 8'h1;
							end
							if (decay_sel == HBC_DEC_MIXED
								&& fcnt[i] == 12'h0) begin
								next_st[i] = HBC_SLOW;
							end
							if (decay_sel == HBC_DEC_AUTO
								&& blk[i] == 8'h0 && !trip[i]) begin
								next_st[i] = HBC_SLOW;
							end
						end
					end
					HBC_SLOW: begin
						if (tmr[i] == 12'h0) begin
							next_st[i]  = HBC_BLANK;
							next_blk[i] = blank_cyc(blank_sel);
						end else begin
							next_tmr[i] = tmr[i] - 12'h1;
						end
					end
					endcase
				end
				unique case (next_st[i])
				HBC_BLANK: next_gate[i] = drive_gates(next_dir[i]);
				HBC_ON:    next_gate[i] = drive_gates(next_dir[i]);
				HBC_FAST:  next_gate[i] = next_zero[i] ? 4'h0
					: drive_gates(~next_dir[i]);
				HBC_SLOW:  next_gate[i] = brake_gates();
				HBC_IDLE:  next_gate[i] = 4'h0;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl      <= `HBC_RST_CTRL;
			scale     <= `HBC_RST_SCALE;
			off_sel   <= `HBC_RST_OFF;
			blank_sel <= `HBC_RST_BLANK;
			fast_sel  <= `HBC_RST_FAST;
			readdata  <= 32'h0;
			ack       <= 1'b0;
			wake_cnt  <= 16'h0;
			awake     <= 1'b0;
			dir       <= 2'h0;
			zero      <= 2'h0;
			for (int i = 0; i < 2; i++) begin
				st[i]   <= HBC_IDLE;
				blk[i]  <= 8'h0;
				tmr[i]  <= 12'h0;
				fcnt[i] <= 12'h0;
				gate[i] <= 4'h0;
			end
		end else begin
			ctrl      <= next_ctrl;
			scale     <= next_scale;
			off_sel   <= next_off_sel;
			blank_sel <= next_blank_sel;
			fast_sel  <= next_fast_sel;
			readdata  <= next_readdata;
			ack       <= next_ack;
			wake_cnt  <= next_wake_cnt;
			awake     <= next_awake;
			dir       <= next_dir;
			zero      <= next_zero;
			for (int i = 0; i < 2; i++) begin
				st[i]   <= next_st[i];
				blk[i]  <= next_blk[i];
				tmr[i]  <= next_tmr[i];
				fcnt[i] <= next_fcnt[i];
				gate[i] <= next_gate[i];
			end
		end
	end

endmodule : hbc_chopper

// *** hdl/hbc_defines.svh ***
`ifndef HBC_DEFINES_SVH
`define HBC_DEFINES_SVH

// Register byte offsets on the Avalon-MM slave.
`define HBC_OFS_CTRL    5'h00
`define HBC_OFS_SCALE   5'h04
`define HBC_OFS_OFF     5'h08
`define HBC_OFS_BLANK   5'h0C
`define HBC_OFS_FAST    5'h10
`define HBC_OFS_STATUS  5'h14

// Control register fields.
`define HBC_CTRL_EN     0
`define HBC_CTRL_GAIN   2:1
`define HBC_CTRL_DECAY  4:3
`define HBC_CTRL_W      5

// Reset values.
`define HBC_RST_CTRL    5'h01
`define HBC_RST_SCALE   8'hFF
`define HBC_RST_OFF     8'h14
`define HBC_RST_BLANK   8'h19
`define HBC_RST_FAST    8'h04

// Status register fields.
`define HBC_ST_A        4:0
`define HBC_ST_B        9:5
`define HBC_ST_AWAKE    10
`define HBC_ST_ZERO     12:11

// Gate enable bits of one bridge.
`define HBC_HS1         3
`define HBC_LS1         2
`define HBC_HS2         1
`define HBC_LS2         0

// Timing, in nanoseconds.
`define HBC_CLK_NS        50
`define HBC_OFF_BASE_NS   525
`define HBC_OFF_STEP_NS   500
`define HBC_BLANK_BASE_NS 500
`define HBC_BLANK_STEP_NS 20
`define HBC_FAST_STEP_NS  500
`define HBC_WAKE_NS       1000000

`endif

// *** hdl/hbc_pkg.sv ***
package hbc_pkg;

	typedef logic [7:0] hbc_code_t;
	typedef logic [1:0] hbc_gain_t;
	typedef logic [3:0] hbc_gate_t;

	typedef enum logic [4:0] {
		HBC_IDLE  = 5'h01,
		HBC_BLANK = 5'h02,
		HBC_ON    = 5'h04,
		HBC_FAST  = 5'h08,
		HBC_SLOW  = 5'h10
	} hbc_state_t;

	typedef enum logic [1:0] {
		HBC_DEC_SLOW  = 2'h0,
		HBC_DEC_FAST  = 2'h1,
		HBC_DEC_MIXED = 2'h2,
		HBC_DEC_AUTO  = 2'h3
	} hbc_decay_t;

endpackage : hbc_pkg

// *** dv/hbc_chopper_properties.sv ***
`timescale 1ns/1ps
module hbc_chopper_properties (
	// Clock and reset.
	input wire logic               clk,
	input wire logic               rstn,
	// Register bus handshake.
	input wire logic               read,
	input wire logic               write,
	input wire logic               waitrequest,
	// Pins.
	input wire logic               low_power_n,
	input wire logic               chan_a_drive_ctl_1,
	input wire logic               chan_a_drive_ctl_2,
	input wire logic               chan_b_drive_ctl_1,
	input wire logic               chan_b_drive_ctl_2,
	// Gate enables.
	input wire hbc_pkg::hbc_gate_t chan_a_gate,
	input wire hbc_pkg::hbc_gate_t chan_b_gate
);
	import hbc_pkg::*;
	wire logic a_fwd = chan_a_drive_ctl_1 & ~chan_a_drive_ctl_2;
	wire logic a_rev = ~chan_a_drive_ctl_1 & chan_a_drive_ctl_2;
	wire logic a_off = ~chan_a_drive_ctl_1 & ~chan_a_drive_ctl_2;
	wire logic b_brk = chan_b_drive_ctl_1 & chan_b_drive_ctl_2;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Pins pass two sync flops and the gate register, low_power_n also awake, so six cycles cover it.
	sequence slow_in_s;
		chan_a_gate == 4'h5 && $past(chan_a_gate) == 4'h9;
	endsequence
	sequence fwd_start_s;
		$rose(a_fwd) ##0 a_fwd[*8];
	endsequence
	sleep_hiz_a: assert property ((!low_power_n)[*6] |->
		chan_a_gate == 4'h0 && chan_b_gate == 4'h0) else $error("asleep");
	coast_hiz_a: assert property (a_off[*6] |-> chan_a_gate == 4'h0)
		else $error("coast");
	rev_drive_a: assert property ($rose(a_rev) ##0 a_rev[*8] |->
		chan_a_gate inside {4'h6, 4'h0}) else $error("reverse");
	blank_hold_a: assert property (fwd_start_s |->
		chan_a_gate inside {4'h9, 4'h0}) else $error("blanking");
	brake_low_a: assert property (b_brk[*6] |->
		chan_b_gate inside {4'h5, 4'h0}) else $error("brake");
	gate_code_a: assert property (
		chan_a_gate inside {4'h0, 4'h5, 4'h6, 4'h9} &&
		chan_b_gate inside {4'h0, 4'h5, 4'h6, 4'h9}) else $error("code");
	off_hold_a: assert property (a_fwd[*4] ##0 slow_in_s ##1 a_fwd[*8]
		|-> chan_a_gate == 4'h5) else $error("off time");
	// One wait state on every fresh access.
	bus_wait_a: assert property ((read || write) && !$past(read || write)
		|-> waitrequest ##1 !waitrequest) else $error("wait state");
endmodule : hbc_chopper_properties

// *** dv/hbc_wind_model.sv ***
`timescale 1ns/1ps
module hbc_wind_model (
	// Clock.
	input  wire logic               clk,
	// Gate enables of one bridge.
	input  wire hbc_pkg::hbc_gate_t gate,
	// Sense code and zero-current flag back to the block.
	output hbc_pkg::hbc_code_t      sense_code,
	output logic                    zero_cur
);
	import hbc_pkg::*;
	// Winding current as magnitude and sign, forward when dir is low.
	logic      dir = 1'b0;
	logic      next_dir;
	hbc_code_t mag = 8'h00;
	hbc_code_t next_mag;
	wire logic drive = gate == 4'h9 || gate == 4'h6;
	// Decay against the current is half the rise rate, so a fast decay
	// lasting one blanking time never reaches zero on its own.
	always_comb begin
		next_dir = dir;
		next_mag = (mag < 8'h02) ? 8'h00 : mag - 8'h02;
		if (gate == 4'h5)
			next_mag = (mag == 8'h00) ? mag : mag - 8'h01;
		if (drive && (mag == 8'h00 || gate[1] == dir)) begin
			next_dir = gate[1];
			next_mag = (mag > 8'hEB) ? 8'hF0 : mag + 8'h04;
		end
	end
	always_ff @(posedge clk) begin
		dir <= next_dir;
		mag <= next_mag;
	end
	assign sense_code = mag;
	assign zero_cur = mag < 8'h04;
endmodule : hbc_wind_model

// *** dv/hbc_chopper_tb.sv ***
`timescale 1ns/1ps
module hbc_chopper_tb;
	import hbc_pkg::*;
	localparam int W = 20;
	logic        clk, rstn, read, write, low_power_n, za, zb;
	logic        a1, a2, b1, b2, waitrequest;
	logic [4:0]  address;
	logic [3:0]  byteenable;
	logic [31:0] writedata, readdata, rd;
	hbc_code_t   sa, sb;
	hbc_gain_t   gain;
	hbc_gate_t   ga, gb;
	int          errors, n_tests, n, i;
	// The status word reads 21 while asleep: both channels idle.
	logic [4:0]  ofs [7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10,
		5'h14, 5'h18};
	logic [7:0]  rst [7] = '{8'h01, 8'hFF, 8'h14, 8'h19, 8'h04,
		8'h21, 8'h00};
	// Pins a1 a2 b1 b2, then expected gates of bridge a and bridge b.
	logic [11:0] pin_tab [4] = '{12'h305, 12'h669, 12'h996, 12'hC50};
	// Decay mode, scale, then first and next gate code after the trip.
	logic [19:0] dec_tab [5] = '{20'h04059, 20'h14060, 20'h24065,
		20'h34059, 20'h31065};
	hbc_chopper #(.WAKE_CYCLES(W)) i_dut (
		.clk(clk), .rstn(rstn), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.low_power_n(low_power_n), .chan_a_drive_ctl_1(a1),
		.chan_a_drive_ctl_2(a2), .chan_b_drive_ctl_1(b1),
		.chan_b_drive_ctl_2(b2), .chan_a_sense_code(sa),
		.chan_b_sense_code(sb), .chan_a_zero_cur(za),
		.chan_b_zero_cur(zb), .sense_gain_sel(gain),
		.chan_a_gate(ga), .chan_b_gate(gb));
	hbc_wind_model i_wa (.clk(clk), .gate(ga), .sense_code(sa),
		.zero_cur(za));
	hbc_wind_model i_wb (.clk(clk), .gate(gb), .sense_code(sb),
		.zero_cur(zb));
	task automatic end_sim;
		$display("errors %0d of %0d checks", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	task automatic tmo;
		errors++;
		$display("[FAIL] wait expected done seen timeout");
		end_sim();
	endtask : tmo
	task automatic chk_w(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_w
	task automatic chk_g(input string nm, input hbc_gate_t e, g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_g
	// Holds the request until waitrequest is sampled low, then releases.
	task automatic bus(input logic w, input logic [4:0] ad,
		input logic [31:0] wd, input logic [3:0] be);
		address <= ad;
		writedata <= wd;
		byteenable <= be;
		write <= w;
		read <= !w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 20)
			tmo();
		@(posedge clk);
	endtask : bus
	task automatic wait_ne(input hbc_gate_t v, input int lim);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ga === v && n < lim);
		if (ga === v)
			tmo();
	endtask : wait_ne
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		rstn = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 5'h00;
		writedata = 32'h0;
		byteenable = 4'hF;
		low_power_n = 1'b0;
		{a1, a2, b1, b2} = 4'h8;
		errors = 0;
		n_tests = 0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (200) @(posedge clk);
		for (i = 0; i < 7; i++) begin
			bus(1'b0, ofs[i], 32'h0, 4'hF);
			chk_w("reset value", {24'h0, rst[i]}, rd);
		end
		chk_w("gain reset", 32'h0, {30'h0, gain});
		chk_g("gate asleep", 4'h0, ga);
		low_power_n <= 1'b1;
		wait_ne(4'h0, W + 12);
		chk_g("gate woken", 4'h9, ga);
		// Awake, channel a blanking, channel b idle.
		bus(1'b0, 5'h14, 32'h0, 4'hF);
		chk_w("status woken", 32'h422, rd);
		for (i = 0; i < 4; i++) begin
			{a1, a2, b1, b2} <= pin_tab[i][11:8];
			repeat (10) @(posedge clk);
			chk_g("gate a", pin_tab[i][7:4], ga);
			chk_g("gate b", pin_tab[i][3:0], gb);
		end
		{a1, a2, b1, b2} <= 4'h9;
		repeat (10) @(posedge clk);
		bus(1'b1, 5'h00, 32'h0, 4'hF);
		repeat (6) @(posedge clk);
		chk_g("gate a off", 4'h0, ga);
		chk_g("gate b off", 4'h0, gb);
		// A write with no byte lane enabled must leave the bridges off.
		bus(1'b1, 5'h00, 32'h1, 4'h0);
		repeat (6) @(posedge clk);
		chk_g("masked write", 4'h0, ga);
		bus(1'b1, 5'h18, 32'hFF, 4'hF);
		bus(1'b0, 5'h18, 32'h0, 4'hF);
		chk_w("unmapped", 32'h0, rd);
		for (i = 0; i < 4; i++) begin
			bus(1'b1, 5'h00, 32'(i * 2 + 1), 4'hF);
			chk_w("gain", 32'(i), {30'h0, gain});
		end
		bus(1'b1, 5'h08, 32'h3, 4'hF);
		bus(1'b1, 5'h0C, 32'h0, 4'hF);
		bus(1'b1, 5'h10, 32'h1, 4'hF);
		for (i = 0; i < 5; i++) begin
			{a1, a2, b1, b2} <= 4'h0;
			n = 0;
			while (sa !== 8'h00 && n < 300) begin
				@(posedge clk);
				n++;
			end
			if (n >= 300)
				tmo();
			bus(1'b1, 5'h04, {24'h0, dec_tab[i][15:8]}, 4'hF);
			bus(1'b1, 5'h00, {27'h0, dec_tab[i][17:16], 3'h1}, 4'hF);
			{a1, a2} <= 2'b10;
			wait_ne(4'h0, 20);
			wait_ne(4'h9, 300);
			chk_g("first decay", dec_tab[i][7:4], ga);
			wait_ne(dec_tab[i][7:4], 300);
			chk_g("next state", dec_tab[i][3:0], ga);
		end
		// A reset in mid-run must idle the bridges and restart the wake.
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		chk_g("gate after reset", 4'h0, ga);
		repeat (200) @(posedge clk);
		bus(1'b0, 5'h00, 32'h0, 4'hF);
		chk_w("ctrl after reset", 32'h1, rd);
		end_sim();
	end
endmodule : hbc_chopper_tb
bind hbc_chopper hbc_chopper_properties i_prop (.clk(clk), .rstn(rstn),
	.read(read), .write(write), .waitrequest(waitrequest),
	.low_power_n(low_power_n), .chan_a_drive_ctl_1(chan_a_drive_ctl_1),
	.chan_a_drive_ctl_2(chan_a_drive_ctl_2),
	.chan_b_drive_ctl_1(chan_b_drive_ctl_1),
	.chan_b_drive_ctl_2(chan_b_drive_ctl_2),
	.chan_a_gate(chan_a_gate), .chan_b_gate(chan_b_gate));
